/* verilog/ecs_pkg.sv */
// package for the external oscillator, clock multiplier and system clock select block
// assumes a single 25 MHz system clock and an 8-bit special function register port
package ecs_pkg;
  // ============================================================
  // register addresses
  localparam logic [7:0] ECS_ADDR_XOSC = 8'hb1;
  localparam logic [7:0] ECS_ADDR_MUL = 8'hb9;
  localparam logic [7:0] ECS_ADDR_CSEL = 8'ha9;
  localparam logic [7:0] ECS_RESET_VAL = 8'h00;
  // ============================================================
  // field positions
  localparam int ECS_XVLD_BIT = 7;
  localparam int ECS_XMODE_HI = 6;
  localparam int ECS_XMODE_LO = 4;
  localparam int ECS_XDRV_HI = 2;
  localparam int ECS_XDRV_LO = 0;
  localparam int ECS_MEN_BIT = 7;
  localparam int ECS_MINIT_BIT = 6;
  localparam int ECS_MRDY_BIT = 5;
  localparam int ECS_MSEL_HI = 1;
  localparam int ECS_MSEL_LO = 0;
  localparam int ECS_CSL_HI = 1;
  localparam int ECS_CSL_LO = 0;
  // ============================================================
  // encodings
  typedef enum logic [2:0] {
    ECS_XM_OFF0 = 3'h0,
    ECS_XM_OFF1 = 3'h1,
    ECS_XM_CMOS = 3'h2,
    ECS_XM_CMOS_DIV2 = 3'h3,
    ECS_XM_RC = 3'h4,
    ECS_XM_CAP = 3'h5,
    ECS_XM_XTAL = 3'h6,
    ECS_XM_XTAL_DIV2 = 3'h7
  } ecs_xmode_type;
  typedef enum logic [1:0] {
    ECS_MI_INT = 2'h0,
    ECS_MI_EXT = 2'h1,
    ECS_MI_EXT_DIV2 = 2'h2,
    ECS_MI_RSVD = 2'h3
  } ecs_msel_type;
  typedef enum logic [1:0] {
    ECS_SC_INT = 2'h0,
    ECS_SC_EXT = 2'h1,
    ECS_SC_MUL_DIV2 = 2'h2,
    ECS_SC_RSVD = 2'h3
  } ecs_csel_type;
  typedef enum logic [1:0] {
    ECS_SW_IDLE = 2'h0,
    ECS_SW_GATE = 2'h1,
    ECS_SW_RUN = 2'h2
  } ecs_sw_type;
  // ============================================================
  // timing
  localparam int ECS_CLK_MHZ = 25;
  localparam int ECS_XTAL_SETTLE_US = 1000;
  localparam int ECS_XTAL_SETTLE_CYC = ECS_XTAL_SETTLE_US * ECS_CLK_MHZ;
  localparam int ECS_LOCK_US = 20;
  localparam int ECS_LOCK_CYC = ECS_LOCK_US * ECS_CLK_MHZ;
  localparam int ECS_MUL_FACTOR = 4;
  localparam int ECS_CNT_W = 16;
  localparam logic [ECS_CNT_W-1:0] ECS_CNT_ONE = 16'h0001;
  localparam logic [ECS_CNT_W-1:0] ECS_CNT_ZERO = 16'h0000;
  localparam int ECS_GATE_CYC = 4;
  localparam logic [2:0] ECS_GATE_LAST = 3'h3;
endpackage : ecs_pkg

/* verilog/ecs_clock_control.sv */
// external oscillator control, 4x multiplier control and system clock source select
// assumes an 8-bit register port on clk; oscillator activity arrives as sync enable pulses
// Notes on behaviour
// RULE_01 - mode field: 00x off, 010 cmos, 011 cmos/2, 100 rc, 101 cap, 11x crystal.
// RULE_02 - bit 7 crystal-valid is read-only; one only when crystal runs stably in 11x.
// RULE_03 - hardware sets crystal-valid once the oscillator has settled after enabling.
// RULE_04 - software waits at least 1 ms after crystal enable before checking valid.
// RULE_05 - three-bit drive range in bits 2..0 is held as software writes it.
// RULE_06 - oscillator control bit 3 reads zero; writes ignored.
// RULE_07 - multiplier bit 7 enables the 4x multiplier.
// RULE_08 - initialize bit must be zero while enabling; writing one once enabled starts init.
// RULE_09 - read-only ready bit 5 goes one after lock following initialization.
// RULE_10 - multiplier input: 00 internal, 01 external, 10 external/2, 11 reserved.
// RULE_11 - software: clear, pick input, enable, wait over 5 us, initialize, poll ready.
// RULE_12 - multiplier output runs at four times its input rate; the model gives four pulses per input pulse, at most one per clk.
// RULE_13 - external source must be stable before multiplier initialization.
// RULE_14 - multiplier bits 4..2 read zero; writes have no effect.
// RULE_15 - internal oscillator is selectable at once, with no start-up wait.
// RULE_16 - system clock runs from external oscillator only when select equals 01.
// RULE_17 - system clock switches on the fly; software picks only settled sources.
// RULE_18 - multiplier output divided by two is a system clock choice.
// RULE_19 - rc and capacitor modes need no start-up delay.
// RULE_20 - select 00 internal, 01 external, 10 multiplier/2, 11 reserved.
// RULE_21 - source switching produces no glitches or runt pulses.
// RULE_22 - ready clears on disable or register clear, stays zero until new init completes.
`timescale 1ns/1ps
module ecs_clock_control
  import ecs_pkg::*;
#(
  parameter int XTAL_SETTLE_CYC = ecs_pkg::ECS_XTAL_SETTLE_CYC
)
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // oscillator tick enables (one pulse per source edge) and the external running level
  input wire logic int_osc_tick,
  input wire logic ext_osc_tick,
  input wire logic ext_osc_running,
  // oscillator circuit control
  output logic [2:0] ext_osc_mode_out,
  output logic [2:0] ext_drive_range_out,
  output logic ext_osc_enable,
  output logic [1:0] multiplier_input_select_out,
  // clock outputs as enable pulses, plus the active source code
  output logic ext_clk_tick,
  output logic mul_clk_tick,
  output logic sys_clk_tick,
  output logic [1:0] sys_clk_active_src
);
  import ecs_pkg::*;

  // ============================================================
  // registers
  logic [2:0] ext_osc_mode_ff;
  logic [2:0] external_drive_range_ff;
  logic crystal_valid_flag_ff;
  logic multiplier_enable_ff;
  logic multiplier_initialize_ff;
  logic multiplier_ready_ff;
  logic [1:0] multiplier_input_select_ff;
  logic [1:0] system_clock_source_ff;
  logic [ECS_CNT_W-1:0] xtal_cnt_ff;
  logic [ECS_CNT_W-1:0] lock_cnt_ff;
  logic init_run_ff;
  logic ext_div_ff;
  logic mul_div_ff;
  logic [1:0] mul_phase_ff;
  logic [1:0] cur_src_ff;
  logic [2:0] gate_cnt_ff;
  ecs_sw_type sw_state_ff;

  logic wr_xosc;
  logic wr_mul;
  logic wr_csel;
  logic is_xtal;
  logic ext_raw;
  logic ext_tick_int;
  logic mul_in_tick;
  logic mul_div2_tick;
  logic pick_tick;
  // the mode field is held as three bits, so its positions are relative to the field
  localparam int XM_TOP = ECS_XMODE_HI - ECS_XMODE_LO;
  localparam int XM_MID = XM_TOP - 1;
  localparam int XM_BOT = ECS_XMODE_LO - ECS_XMODE_LO;
  assign wr_xosc = reg_wr && (reg_addr == ECS_ADDR_XOSC);
  assign wr_mul = reg_wr && (reg_addr == ECS_ADDR_MUL);
  assign wr_csel = reg_wr && (reg_addr == ECS_ADDR_CSEL);
  assign is_xtal = ext_osc_mode_ff[XM_TOP] && ext_osc_mode_ff[XM_MID];

  // ============================================================
  // external oscillator control
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      ext_osc_mode_ff <= 3'h0;
      external_drive_range_ff <= 3'h0;
    end
    else if (wr_xosc)
    begin
      ext_osc_mode_ff <= reg_wdata[ECS_XMODE_HI:ECS_XMODE_LO]; // RULE_01
      external_drive_range_ff <= reg_wdata[ECS_XDRV_HI:ECS_XDRV_LO]; // RULE_05
    end
  end

  // crystal settle timer restarts on any mode write; rc/cap/cmos need none
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      xtal_cnt_ff <= ECS_CNT_ZERO;
      crystal_valid_flag_ff <= 1'b0;
    end
    else if (wr_xosc || !is_xtal || !ext_osc_running)
    begin
      xtal_cnt_ff <= ECS_CNT_ZERO;
      crystal_valid_flag_ff <= 1'b0; // RULE_02
    end
    else if (xtal_cnt_ff >= ECS_CNT_W'(XTAL_SETTLE_CYC - 1))
    begin
      crystal_valid_flag_ff <= 1'b1; // RULE_03
    end
    else
    begin
      xtal_cnt_ff <= xtal_cnt_ff + ECS_CNT_ONE;
    end
  end

  // ============================================================
  // external clock path: mode decode and optional divide by two
  always_comb
  begin
    unique case (ecs_xmode_type'(ext_osc_mode_ff)) // RULE_01
      ECS_XM_OFF0, ECS_XM_OFF1: ext_raw = 1'b0;
      default: ext_raw = ext_osc_tick; // RULE_19
    endcase
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      ext_div_ff <= 1'b0;
    else if (ext_raw)
      ext_div_ff <= ~ext_div_ff;
  end

  assign ext_tick_int = ext_osc_mode_ff[XM_BOT] && ext_osc_mode_ff[XM_BOT+1]
                        ? (ext_raw && ext_div_ff) : ext_raw;

  // ============================================================
  // multiplier control
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      multiplier_enable_ff <= 1'b0;
      multiplier_initialize_ff <= 1'b0;
      multiplier_input_select_ff <= 2'h0;
    end
    else if (wr_mul)
    begin
      multiplier_enable_ff <= reg_wdata[ECS_MEN_BIT]; // RULE_07
      // init only takes when already enabled
      multiplier_initialize_ff <= reg_wdata[ECS_MINIT_BIT] && multiplier_enable_ff; // RULE_08
      multiplier_input_select_ff <= reg_wdata[ECS_MSEL_HI:ECS_MSEL_LO];
    end
  end

  // lock model: fixed lock time after init, counted in clk cycles
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      lock_cnt_ff <= ECS_CNT_ZERO;
      init_run_ff <= 1'b0;
      multiplier_ready_ff <= 1'b0;
    end
    else if (!multiplier_enable_ff || (wr_mul && !reg_wdata[ECS_MINIT_BIT]))
    begin
      lock_cnt_ff <= ECS_CNT_ZERO;
      init_run_ff <= 1'b0;
      multiplier_ready_ff <= 1'b0; // RULE_22
    end
    else if (wr_mul && reg_wdata[ECS_MINIT_BIT] && !multiplier_initialize_ff)
    begin
      lock_cnt_ff <= ECS_CNT_ZERO;
      init_run_ff <= 1'b1; // RULE_08
      multiplier_ready_ff <= 1'b0;
    end
    else if (init_run_ff)
    begin
      if (lock_cnt_ff >= ECS_CNT_W'(ECS_LOCK_CYC - 1))
      begin
        init_run_ff <= 1'b0;
        multiplier_ready_ff <= 1'b1; // RULE_09
      end
      else
        lock_cnt_ff <= lock_cnt_ff + ECS_CNT_ONE;
    end
  end

  // input select; reserved code gives no input
  always_comb
  begin
    unique case (ecs_msel_type'(multiplier_input_select_ff)) // RULE_10
      ECS_MI_INT: mul_in_tick = int_osc_tick;
      ECS_MI_EXT: mul_in_tick = ext_raw;
      ECS_MI_EXT_DIV2: mul_in_tick = ext_raw && ext_div_ff;
      ECS_MI_RSVD: mul_in_tick = 1'b0;
    endcase
  end

  // 4x is modelled as four output pulses per input pulse; limited by clk rate
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      mul_phase_ff <= 2'h0;
    else if (!multiplier_ready_ff)
      mul_phase_ff <= 2'h0;
    else if (mul_in_tick)
      mul_phase_ff <= 2'(ECS_MUL_FACTOR - 1); // RULE_12
    else if (mul_phase_ff != 2'h0)
      mul_phase_ff <= mul_phase_ff - 2'h1;
  end

  logic mul_tick_int;
  assign mul_tick_int = multiplier_ready_ff && (mul_in_tick || (mul_phase_ff != 2'h0));

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      mul_div_ff <= 1'b0;
    else if (mul_tick_int)
      mul_div_ff <= ~mul_div_ff;
  end
  assign mul_div2_tick = mul_tick_int && mul_div_ff; // RULE_18

  // ============================================================
  // system clock select with glitch-free handover
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      system_clock_source_ff <= 2'h0;
    else if (wr_csel)
      system_clock_source_ff <= reg_wdata[ECS_CSL_HI:ECS_CSL_LO]; // RULE_17
  end

  // old source is stopped for a few quiet cycles before the new one starts
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      sw_state_ff <= ECS_SW_RUN;
      cur_src_ff <= 2'h0;
      gate_cnt_ff <= 3'h0;
    end
    else
    begin
      unique case (sw_state_ff)
        ECS_SW_RUN:
          if (system_clock_source_ff != cur_src_ff && system_clock_source_ff != ECS_SC_RSVD)
          begin
            sw_state_ff <= ECS_SW_GATE; // RULE_21
            gate_cnt_ff <= 3'h0;
          end
        ECS_SW_GATE:
          if (gate_cnt_ff == ECS_GATE_LAST)
          begin
            cur_src_ff <= system_clock_source_ff;
            sw_state_ff <= ECS_SW_IDLE;
          end
          else
            gate_cnt_ff <= gate_cnt_ff + 3'h1;
        ECS_SW_IDLE:
          sw_state_ff <= ECS_SW_RUN;
        default:
          sw_state_ff <= ECS_SW_RUN;
      endcase
    end
  end

  always_comb
  begin
    unique case (ecs_csel_type'(cur_src_ff)) // RULE_20
      ECS_SC_INT: pick_tick = int_osc_tick; // RULE_15
      ECS_SC_EXT: pick_tick = ext_tick_int; // RULE_16
      ECS_SC_MUL_DIV2: pick_tick = mul_div2_tick; // RULE_18
      ECS_SC_RSVD: pick_tick = 1'b0;
    endcase
  end

  // ============================================================
  // registered outputs
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      sys_clk_tick <= 1'b0;
      ext_clk_tick <= 1'b0;
      mul_clk_tick <= 1'b0;
      sys_clk_active_src <= 2'h0;
      ext_osc_mode_out <= 3'h0;
      ext_drive_range_out <= 3'h0;
      ext_osc_enable <= 1'b0;
      multiplier_input_select_out <= 2'h0;
    end
    else
    begin
      sys_clk_tick <= (sw_state_ff == ECS_SW_RUN) && pick_tick; // RULE_21
      ext_clk_tick <= ext_tick_int;
      mul_clk_tick <= mul_tick_int;
      sys_clk_active_src <= cur_src_ff;
      ext_osc_mode_out <= ext_osc_mode_ff;
      ext_drive_range_out <= external_drive_range_ff;
      ext_osc_enable <= ext_osc_mode_ff[XM_TOP] || ext_osc_mode_ff[XM_MID]; // RULE_01
      multiplier_input_select_out <= multiplier_input_select_ff;
    end
  end

  // read data registered; unmapped addresses read zero
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      reg_rdata <= ECS_RESET_VAL;
    else if (reg_rd)
    begin
      unique case (reg_addr)
        ECS_ADDR_XOSC: reg_rdata <= {crystal_valid_flag_ff && is_xtal, ext_osc_mode_ff,
                                     1'b0, external_drive_range_ff}; // RULE_06
        ECS_ADDR_MUL: reg_rdata <= {multiplier_enable_ff, multiplier_initialize_ff,
                                    multiplier_ready_ff, 3'h0,
                                    multiplier_input_select_ff}; // RULE_14
        ECS_ADDR_CSEL: reg_rdata <= {6'h00, system_clock_source_ff};
        default: reg_rdata <= ECS_RESET_VAL;
      endcase
    end
  end
endmodule : ecs_clock_control

/* tb/ecs_clock_control_checker.sv */
// concurrent checks on the clock control block's ports
// assumes one clock domain, reads answered on the registered read port
`timescale 1ns/1ps
module ecs_clock_control_checker
  import ecs_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // block outputs
  input wire logic [2:0] ext_osc_mode_out,
  input wire logic [2:0] ext_drive_range_out,
  input wire logic ext_osc_enable,
  input wire logic [1:0] multiplier_input_select_out,
  input wire logic sys_clk_tick,
  input wire logic [1:0] sys_clk_active_src
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // ====
  // helper: write data two edges back, since the copies on the outputs lag by two edges
  logic [7:0] wd_ff;
  logic [7:0] wd2_ff;
  always_ff @(posedge clk)
  begin
    wd_ff <= reg_wdata;
    wd2_ff <= wd_ff;
  end
  // ====
  // properties
  property p_en_mode;
    ext_osc_enable == (ext_osc_mode_out[2:1] != 2'b00);
  endproperty
  a_en_mode: assert property (p_en_mode) else $error("enable disagrees with mode");
  property p_mode_wr;
    reg_wr && reg_addr == ECS_ADDR_XOSC |-> ##2 ext_osc_mode_out == wd2_ff[6:4];
  endproperty
  a_mode_wr: assert property (p_mode_wr) else $error("mode not taken");
  property p_drv_wr;
    reg_wr && reg_addr == ECS_ADDR_XOSC |-> ##2 ext_drive_range_out == wd2_ff[2:0];
  endproperty
  a_drv_wr: assert property (p_drv_wr) else $error("drive range not taken");
  property p_msel_wr;
    reg_wr && reg_addr == ECS_ADDR_MUL |-> ##2 multiplier_input_select_out == wd2_ff[1:0];
  endproperty
  a_msel_wr: assert property (p_msel_wr) else $error("input select not taken");
  property p_bit3;
    reg_rd && reg_addr == ECS_ADDR_XOSC ##1 !reg_rd |=> !reg_rdata[3];
  endproperty
  a_bit3: assert property (p_bit3) else $error("reserved bit reads one");
  property p_bits42;
    reg_rd && reg_addr == ECS_ADDR_MUL ##1 !reg_rd |=> reg_rdata[4:2] == 3'h0;
  endproperty
  a_bits42: assert property (p_bits42) else $error("unused bits read nonzero");
  property p_vld;
    reg_rd && reg_addr == ECS_ADDR_XOSC && ext_osc_mode_out[2:1] != 2'b11
      ##1 !reg_rd && !reg_wr |=> !reg_rdata[7];
  endproperty
  a_vld: assert property (p_vld) else $error("valid set outside crystal mode");
  property p_rdy_en;
    reg_rd && reg_addr == ECS_ADDR_MUL ##1 !reg_rd && !reg_wr |=> !reg_rdata[5] || reg_rdata[7];
  endproperty
  a_rdy_en: assert property (p_rdy_en) else $error("ready while disabled");
  property p_src_rsvd;
    sys_clk_active_src != ECS_SC_RSVD;
  endproperty
  a_src_rsvd: assert property (p_src_rsvd) else $error("reserved source active");
  property p_quiet;
    $changed(sys_clk_active_src) |-> !$past(sys_clk_tick) && !$past(sys_clk_tick, 2);
  endproperty
  a_quiet: assert property (p_quiet) else $error("tick near handover");
  c_ext: cover property (sys_clk_active_src == ECS_SC_EXT);
  c_mul: cover property (sys_clk_active_src == ECS_SC_MUL_DIV2);
  c_rdy: cover property (reg_rd && reg_addr == ECS_ADDR_MUL ##2 reg_rdata[5]);
endmodule : ecs_clock_control_checker

bind ecs_clock_control ecs_clock_control_checker u_chk (.clk, .reset, .reg_addr, .reg_wr,
  .reg_rd, .reg_wdata, .reg_rdata, .ext_osc_mode_out, .ext_drive_range_out, .ext_osc_enable,
  .multiplier_input_select_out, .sys_clk_tick, .sys_clk_active_src);

/* tb/ecs_osc_model.sv */
// oscillator sources at the far side of the clock control block
// assumes sources appear as enable pulses on the bench clock
`timescale 1ns/1ps
module ecs_osc_model (
  // clock
  input wire logic clk,
  // circuit control from the block
  input wire logic ext_osc_enable,
  input wire logic [2:0] ext_osc_mode_out,
  // sources
  output logic int_osc_tick,
  output logic ext_osc_tick,
  output logic ext_osc_running
);
  logic [3:0] ph_ff = 4'h0;
  logic [3:0] up_ff = 4'h0;
  always @(posedge clk)
  begin
    ph_ff <= ph_ff + 4'h1;
    up_ff <= !ext_osc_enable ? 4'h0 : (up_ff == 4'hf ? up_ff : up_ff + 4'h1);
  end
  assign int_osc_tick = ph_ff[0];
  assign ext_osc_tick = ext_osc_enable && ph_ff[2:0] == 3'h7;
  // a crystal needs amplitude build-up, rc and cap run at once
  assign ext_osc_running = ext_osc_enable && (ext_osc_mode_out[2:1] != 2'b11 || up_ff > 4'h9);
endmodule : ecs_osc_model

/* tb/testbench.sv */
// self-checking bench for the clock control block
// assumes the oscillator model at the far side and the bound checker
`timescale 1ns/1ps
module testbench;
  import ecs_pkg::*;
  logic clk, reset, reg_wr, reg_rd, rd_d1, rd_d2, ext_osc_enable;
  logic int_osc_tick, ext_osc_tick, ext_osc_running, ext_clk_tick, mul_clk_tick, sys_clk_tick;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, r;
  logic [2:0] ext_osc_mode_out, ext_drive_range_out;
  logic [1:0] multiplier_input_select_out, sys_clk_active_src;
  logic [7:0] q[$];
  int err_total = 0;
  int cmp_count = 0;
  int seed = 58;
  int n_ext, n_mul, n_xck;
  ecs_clock_control #(.XTAL_SETTLE_CYC(20)) u_dut (.clk, .reset, .reg_addr, .reg_wr, .reg_rd,
    .reg_wdata, .reg_rdata, .int_osc_tick, .ext_osc_tick, .ext_osc_running, .ext_osc_mode_out,
    .ext_drive_range_out, .ext_osc_enable, .multiplier_input_select_out, .ext_clk_tick,
    .mul_clk_tick, .sys_clk_tick, .sys_clk_active_src);
  ecs_osc_model u_osc (.clk, .ext_osc_enable, .ext_osc_mode_out, .int_osc_tick, .ext_osc_tick,
    .ext_osc_running);
  initial
  begin
    clk = 0;
    forever #20 clk = ~clk;
  end
  // ====
  // tasks
  task chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1;
    @(negedge clk);
    reg_wr = 0;
  endtask : wr
  // reads are spaced so the answer stands before the next request
  task rd(input logic [7:0] a, input logic [7:0] e);
    q.push_back(e);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1;
    @(negedge clk);
    reg_rd = 0;
    @(negedge clk);
  endtask : rd
  task final_report;
    $display("errors %0d comparisons %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : final_report
  // ====
  // read monitor
  always @(posedge clk)
  begin
    rd_d1 <= reg_rd;
    rd_d2 <= rd_d1;
  end
  always @(negedge clk)
    if (rd_d2 === 1'b1)
      chk(reg_rdata, q.pop_front());
  initial
  begin
    repeat (5000) @(posedge clk);
    err_total++;
    final_report();
  end
  // ====
  // main sequence
  initial
  begin
    reset = 1;
    reg_wr = 0;
    reg_rd = 0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    repeat (3) @(negedge clk);
    reset = 0;
    rd(ECS_ADDR_XOSC, 8'h00);
    rd(ECS_ADDR_MUL, 8'h00);
    rd(ECS_ADDR_CSEL, 8'h00);
    r = 8'($random(seed));
    r[7] = 1'b0;
    wr(r, 8'hff);
    rd(r, 8'h00);
    for (int m = 0; m < 8; m++)
    begin
      r = 8'($random(seed));
      wr(ECS_ADDR_XOSC, {r[7], 3'(m), r[3:0]});
      rd(ECS_ADDR_XOSC, {1'b0, 3'(m), 1'b0, r[2:0]});
    end
    wr(ECS_ADDR_XOSC, 8'h67);
    repeat (40) @(negedge clk);
    rd(ECS_ADDR_XOSC, 8'he7);
    wr(ECS_ADDR_XOSC, 8'h47);
    for (int s = 0; s < 4; s++)
    begin
      r = 8'($random(seed));
      wr(ECS_ADDR_MUL, {2'b00, r[5:2], 2'(s)});
      rd(ECS_ADDR_MUL, {6'h00, 2'(s)});
    end
    wr(ECS_ADDR_MUL, 8'h41);
    rd(ECS_ADDR_MUL, 8'h01);
    wr(ECS_ADDR_MUL, 8'h00);
    wr(ECS_ADDR_MUL, 8'h01);
    wr(ECS_ADDR_MUL, 8'h81);
    repeat (130) @(negedge clk);
    wr(ECS_ADDR_MUL, 8'hc1);
    repeat (520) @(negedge clk);
    rd(ECS_ADDR_MUL, 8'he1);
    n_ext = 0;
    n_mul = 0;
    n_xck = 0;
    repeat (400)
    begin
      @(negedge clk);
      n_ext += ext_osc_tick;
      n_mul += mul_clk_tick;
      n_xck += ext_clk_tick;
    end
    chk(8'(n_mul + 4 >= 4 * n_ext && n_mul <= 4 * n_ext + 4), 8'h01);
    chk(8'(n_xck), 8'(n_ext));
    for (int k = 1; k < 5; k++)
    begin
      wr(ECS_ADDR_CSEL, 8'(k % 4));
      repeat (12) @(negedge clk);
      chk({6'h00, sys_clk_active_src}, k == 3 ? 8'h02 : 8'(k % 4));
      if (k == 1)
      begin
        n_ext = 0;
        n_mul = 0;
        repeat (48)
        begin
          @(negedge clk);
          n_ext += ext_osc_tick;
          n_mul += sys_clk_tick;
        end
        chk(8'(n_mul), 8'(n_ext));
      end
    end
    wr(ECS_ADDR_MUL, 8'h01);
    rd(ECS_ADDR_MUL, 8'h01);
    wr(ECS_ADDR_XOSC, 8'h47);
    @(negedge clk);
    #7 reset = 1;
    repeat (3) @(negedge clk);
    reset = 0;
    rd(ECS_ADDR_XOSC, 8'h00);
    @(negedge clk);
    final_report();
  end
endmodule : testbench
